// [srr_pkg.sv]
package srr_pkg;

  // ****************************************
  // Clock and timing
  // ****************************************
  localparam int CLK_HZ = 20_000_000;
  localparam int CTS_WAIT_MS = 2000;
  // Longest wait, so the cycle count rounds down
  localparam int CTS_WAIT_CYC = (CLK_HZ / 1000) * CTS_WAIT_MS;

  // ****************************************
  // Status word low byte
  // ****************************************
  localparam logic [7:0] STAT_OK = 8'h01;
  localparam logic [7:0] STAT_FAIL = 8'h02;

  // ****************************************
  // Secondary error codes, status word high byte
  // ****************************************
  localparam logic [7:0] SEC_NONE = 8'h00;
  localparam logic [7:0] SEC_TIMEOUT = 8'h01;
  localparam logic [7:0] SEC_WP_SCRATCH = 8'h02;
  localparam logic [7:0] SEC_NO_IO = 8'h03;
  localparam logic [7:0] SEC_TOO_MUCH = 8'h04;
  localparam logic [7:0] SEC_ODD_BYTES = 8'h05;
  localparam logic [7:0] SEC_NO_REG = 8'h06;
  localparam logic [7:0] SEC_ZERO_LEN = 8'h07;
  localparam logic [7:0] SEC_PROT_MEM = 8'h08;
  localparam logic [7:0] SEC_BAD_TYPE = 8'h09;
  localparam logic [7:0] SEC_NO_DIAG = 8'h0A;
  localparam logic [7:0] SEC_BAD_START = 8'h0B;
  localparam logic [7:0] SEC_BLOCK_RETRY = 8'h0C;
  localparam logic [7:0] SEC_HEADER_RETRY = 8'h0D;
  localparam logic [7:0] SEC_QUERY_RETRY = 8'h0E;
  localparam logic [7:0] SEC_NOT_SLAVE = 8'h0F;
  localparam logic [7:0] SEC_BLOCK_CHAR = 8'h14;
  localparam logic [7:0] SEC_NO_EOT = 8'h15;
  localparam logic [7:0] SEC_NO_ACKNAK = 8'h16;
  localparam logic [7:0] SEC_MASTER_ENQ = 8'h17;
  localparam logic [7:0] SEC_PEER_NAK = 8'h18;
  localparam logic [7:0] SEC_PEER_NORESP = 8'h19;
  localparam logic [7:0] SEC_CTS = 8'h1A;
  localparam logic [7:0] SEC_HOST_XFER = 8'h1D;
  localparam logic [7:0] SEC_PORT_BUSY = 8'h30;
  localparam logic [7:0] SEC_BAD_CMD = 8'h41;

  // ****************************************
  // Limits and command numbers
  // ****************************************
  localparam logic [3:0] RETRY_LIMIT_DEF = 4'h3;
  localparam logic [5:0] ENQ_LIMIT_DEF = 6'h20;
  localparam logic [15:0] CMD_QRESP = 16'h1771;
  localparam logic [15:0] CMD_INT_HI = 16'h1773;
  localparam logic [15:0] CMD_SER_LO = 16'h17D5;
  localparam logic [15:0] CMD_SER_HI = 16'h17E1;

  // ****************************************
  // Fault cause vector positions, lowest wins
  // ****************************************
  localparam int NCAUSE = 15;
  localparam int FC_TIMEOUT = 0;
  localparam int FC_WP_SCRATCH = 1;
  localparam int FC_NO_IO = 2;
  localparam int FC_TOO_MUCH = 3;
  localparam int FC_ODD_BYTES = 4;
  localparam int FC_NO_REG = 5;
  localparam int FC_ZERO_LEN = 6;
  localparam int FC_PROT_MEM = 7;
  localparam int FC_BAD_TYPE = 8;
  localparam int FC_NO_DIAG = 9;
  localparam int FC_BAD_START = 10;
  localparam int FC_BLOCK_CHAR = 11;
  localparam int FC_NO_EOT = 12;
  localparam int FC_NO_ACKNAK = 13;
  localparam int FC_HOST_XFER = 14;

  // Lane positions of the two attempt counters
  localparam int LN_BLOCK = 0;
  localparam int LN_HEADER = 1;
  localparam int LN_QUERY = 2;
  localparam int LN_MASTER = 0;
  localparam int LN_PEER_NAK = 1;
  localparam int LN_PEER_NORESP = 2;

  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_POST} srr_state_e;

endpackage

// [srr_limit_ctr.sv]
`timescale 1ns/10ps

// Counts failed attempts per lane; hit pulses with the failure that reaches limit plus OFFSET
module srr_limit_ctr #(
  parameter int LANES = 3,
  parameter int W = 4,
  parameter int OFFSET = 0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Control
  input wire logic clr,
  input wire logic [LANES-1:0] evt,
  input wire logic [W-1:0] limit,
  // Result
  output logic [LANES-1:0] hit
);

  if (LANES < 1 || W < 1 || OFFSET < 0 || OFFSET > 1) begin : g_chk
    $error("srr_limit_ctr: unsupported parameters");
  end

  logic [W:0] cnt_r [LANES];
  logic [W:0] cnt_nxt [LANES];
  logic [W:0] target;

  assign target = {1'b0, limit} + (W+1)'(OFFSET);

  always_comb begin
    for (int i = 0; i < LANES; i++) begin
      hit[i] = evt[i] && ((cnt_r[i] + (W+1)'(1)) == target);
      if (clr) begin
        cnt_nxt[i] = '0;
      end else if (evt[i]) begin
        cnt_nxt[i] = cnt_r[i] + (W+1)'(1);
      end else begin
        cnt_nxt[i] = cnt_r[i];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < LANES; i++) begin
        cnt_r[i] <= '0;
      end
    end else begin
      for (int i = 0; i < LANES; i++) begin
        cnt_r[i] <= cnt_nxt[i];
      end
    end
  end

endmodule // srr_limit_ctr

// [srr_status_reporter.sv]
`timescale 1ns/10ps

// Summary of operation
// - The status word written back is never zero, whatever the outcome.
// - Error-free completion puts 1 in the status low byte.
// - A failed request puts a value above 1 in the low byte.
// - High byte carries the secondary error code; 00 means success.
// - The same secondary code is copied to diagnostic word one low byte.
// - Serial link timeout reports code 01.
// - Write to fixed-protected scratch pad gives 02; other protected memory 08.
// - Missing I/O point 03, missing registers 06, bad memory type 09.
// - Too much data for a memory type gives 04; zero bytes gives 07.
// - Odd byte count to registers or diagnostic words gives 05.
// - Bad scratch-pad start or unaligned I/O table start gives 0B.
// - Retry limit, default three: data block 0C, header 0D, query 0E.
// - Loading query reply data on a non-slave port gives 0F.
// - Bad framing character or parity, framing, overrun in data block gives 14.
// - Missing EOT gives 15; missing ACK or NAK gives 16.
// - Master enquire without valid acknowledge after limit, default 32, gives 17.
// - Peer enquire NAKed limit times gives 18; no response limit times 19.
// - Clear-to-send inactive too long while waiting to transmit gives 1A.
// - Transfer error between module and host CPU gives 1D.
// - Request on a port already in use is rejected with 30.
// - Unrecognised command number is rejected with 41.
module srr_status_reporter #(
  parameter int CTS_WAIT_CYCLES = srr_pkg::CTS_WAIT_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Request from host
  input wire logic reqStart,
  input wire logic [15:0] reqCmd,
  // Port configuration
  input wire logic cfgSlave,
  input wire logic [3:0] cfgRetryLimit,
  input wire logic [5:0] cfgEnqLimit,
  // Serial engine events
  input wire logic [srr_pkg::NCAUSE-1:0] faultCause,
  input wire logic evtDone,
  input wire logic blockFail,
  input wire logic headerFail,
  input wire logic queryFail,
  input wire logic enqNoAck,
  input wire logic enqNak,
  input wire logic enqNoResp,
  input wire logic txWait,
  // Clear-to-send pin, active high
  input wire logic ctsPin,
  // Request progress
  output logic portBusy,
  output logic xferAbort,
  // Status results
  output logic statusWe,
  output logic [15:0] statusWord,
  output logic [7:0] diagCode
);

  if (CTS_WAIT_CYCLES < 1) begin : g_chk
    $error("srr_status_reporter: CTS_WAIT_CYCLES must be at least 1");
  end

  localparam int CW = $clog2(CTS_WAIT_CYCLES + 1);

  // ****************************************
  // Functions
  // ****************************************

  // Low byte is never zero, so the host can poll a cleared word
  function automatic logic [15:0] mkWord(input logic [7:0] code);
    logic [7:0] low;
    low = (code == srr_pkg::SEC_NONE) ? srr_pkg::STAT_OK : srr_pkg::STAT_FAIL;
    return {code, low};
  endfunction

  function automatic logic cmdKnown(input logic [15:0] cmd);
    return (cmd >= srr_pkg::CMD_QRESP && cmd <= srr_pkg::CMD_INT_HI) ||
           (cmd >= srr_pkg::CMD_SER_LO && cmd <= srr_pkg::CMD_SER_HI);
  endfunction

  // Lowest set position wins when the engine flags several causes at once
  function automatic logic [7:0] pickCause(input logic [srr_pkg::NCAUSE-1:0] c);
    logic [7:0] code;
    code = srr_pkg::SEC_NONE;
    for (int i = srr_pkg::NCAUSE - 1; i >= 0; i--) begin
      if (c[i]) begin
        unique case (i)
          srr_pkg::FC_TIMEOUT: code = srr_pkg::SEC_TIMEOUT;
          srr_pkg::FC_WP_SCRATCH: code = srr_pkg::SEC_WP_SCRATCH;
          srr_pkg::FC_NO_IO: code = srr_pkg::SEC_NO_IO;
          srr_pkg::FC_TOO_MUCH: code = srr_pkg::SEC_TOO_MUCH;
          srr_pkg::FC_ODD_BYTES: code = srr_pkg::SEC_ODD_BYTES;
          srr_pkg::FC_NO_REG: code = srr_pkg::SEC_NO_REG;
          srr_pkg::FC_ZERO_LEN: code = srr_pkg::SEC_ZERO_LEN;
          srr_pkg::FC_PROT_MEM: code = srr_pkg::SEC_PROT_MEM;
          srr_pkg::FC_BAD_TYPE: code = srr_pkg::SEC_BAD_TYPE;
          srr_pkg::FC_NO_DIAG: code = srr_pkg::SEC_NO_DIAG;
          srr_pkg::FC_BAD_START: code = srr_pkg::SEC_BAD_START;
          srr_pkg::FC_BLOCK_CHAR: code = srr_pkg::SEC_BLOCK_CHAR;
          srr_pkg::FC_NO_EOT: code = srr_pkg::SEC_NO_EOT;
          srr_pkg::FC_NO_ACKNAK: code = srr_pkg::SEC_NO_ACKNAK;
          default: code = srr_pkg::SEC_HOST_XFER;
        endcase
      end
    end
    return code;
  endfunction

  // ****************************************
  // Declarations
  // ****************************************
  srr_pkg::srr_state_e state_r, state_nxt;
  logic [7:0] code_r, code_nxt;
  logic statusWe_r, statusWe_nxt;
  logic [15:0] statusWord_r, statusWord_nxt;
  logic [7:0] diagCode_r, diagCode_nxt;
  logic xferAbort_r, xferAbort_nxt;
  logic cts1_r, cts2_r, cts3_r, ctsOn_r, ctsOn_nxt;
  logic [CW-1:0] ctsCnt_r, ctsCnt_nxt;
  logic running, ctrClr, ctsWaiting, ctsHit, reject, finish;
  logic [7:0] finCode;
  logic [3:0] retryLimit;
  logic [5:0] enqLimit;
  logic [2:0] retryHit, enqHit;

  assign running = (state_r == srr_pkg::ST_RUN);
  assign ctrClr = !running;
  assign portBusy = (state_r != srr_pkg::ST_IDLE);
  // A zero limit in the configuration falls back to the default
  assign retryLimit = (cfgRetryLimit == 4'h0) ? srr_pkg::RETRY_LIMIT_DEF : cfgRetryLimit;
  assign enqLimit = (cfgEnqLimit == 6'h00) ? srr_pkg::ENQ_LIMIT_DEF : cfgEnqLimit;

  // ****************************************
  // Attempt counters
  // ****************************************

  // Retries: abort on the failure after the allowed retries are spent
  srr_limit_ctr #(
    .LANES(3),
    .W(4),
    .OFFSET(1)
  ) u_retry (
    .clk(clk),
    .rst_b(rst_b),
    .clr(ctrClr),
    .evt({queryFail, headerFail, blockFail} & {3{running}}),
    .limit(retryLimit),
    .hit(retryHit)
  );

  // Enquires: abort when the failed attempts reach the limit
  srr_limit_ctr #(
    .LANES(3),
    .W(6),
    .OFFSET(0)
  ) u_enq (
    .clk(clk),
    .rst_b(rst_b),
    .clr(ctrClr),
    .evt({enqNoResp, enqNak, enqNoAck} & {3{running}}),
    .limit(enqLimit),
    .hit(enqHit)
  );

  // ****************************************
  // Clear-to-send wait timer
  // ****************************************
  assign ctsWaiting = running && txWait && !ctsOn_r;
  assign ctsHit = ctsWaiting && (ctsCnt_r == CW'(CTS_WAIT_CYCLES - 1));

  always_comb begin
    // Pin level is taken only when the second and third stages agree
    ctsOn_nxt = (cts2_r == cts3_r) ? cts3_r : ctsOn_r;
    ctsCnt_nxt = ctsWaiting ? ctsCnt_r + CW'(1) : '0;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cts1_r <= 1'b0;
      cts2_r <= 1'b0;
      cts3_r <= 1'b0;
      ctsOn_r <= 1'b0;
      ctsCnt_r <= '0;
    end else begin
      cts1_r <= ctsPin;
      cts2_r <= cts1_r;
      cts3_r <= cts2_r;
      ctsOn_r <= ctsOn_nxt;
      ctsCnt_r <= ctsCnt_nxt;
    end
  end

  // ****************************************
  // Outcome selection
  // ****************************************

  // Explicit faults first, then exhausted limits, then CTS, then success
  always_comb begin
    finish = 1'b1;
    finCode = srr_pkg::SEC_NONE;
    if (|faultCause) begin
      finCode = pickCause(faultCause);
    end else if (retryHit[srr_pkg::LN_BLOCK]) begin
      finCode = srr_pkg::SEC_BLOCK_RETRY;
    end else if (retryHit[srr_pkg::LN_HEADER]) begin
      finCode = srr_pkg::SEC_HEADER_RETRY;
    end else if (retryHit[srr_pkg::LN_QUERY]) begin
      finCode = srr_pkg::SEC_QUERY_RETRY;
    end else if (enqHit[srr_pkg::LN_MASTER]) begin
      finCode = srr_pkg::SEC_MASTER_ENQ;
    end else if (enqHit[srr_pkg::LN_PEER_NAK]) begin
      finCode = srr_pkg::SEC_PEER_NAK;
    end else if (enqHit[srr_pkg::LN_PEER_NORESP]) begin
      finCode = srr_pkg::SEC_PEER_NORESP;
    end else if (ctsHit) begin
      finCode = srr_pkg::SEC_CTS;
    end else if (!evtDone) begin
      finish = 1'b0;
    end
  end

  // ****************************************
  // Request sequencing and status write-back
  // ****************************************

  // A second request while busy gets its own answer at once
  assign reject = reqStart && (state_r != srr_pkg::ST_IDLE);

  always_comb begin
    state_nxt = state_r;
    code_nxt = code_r;
    statusWe_nxt = 1'b0;
    statusWord_nxt = statusWord_r;
    diagCode_nxt = diagCode_r;
    xferAbort_nxt = 1'b0;
    unique case (state_r)
      srr_pkg::ST_IDLE: begin
        if (reqStart) begin
          if (!cmdKnown(reqCmd)) begin
            code_nxt = srr_pkg::SEC_BAD_CMD;
            state_nxt = srr_pkg::ST_POST;
          end else if (reqCmd == srr_pkg::CMD_QRESP) begin
            // Internal command: finishes without touching the serial link
            code_nxt = cfgSlave ? srr_pkg::SEC_NONE : srr_pkg::SEC_NOT_SLAVE;
            state_nxt = srr_pkg::ST_POST;
          end else begin
            state_nxt = srr_pkg::ST_RUN;
          end
        end
      end
      srr_pkg::ST_RUN: begin
        if (finish) begin
          code_nxt = finCode;
          xferAbort_nxt = (finCode != srr_pkg::SEC_NONE);
          state_nxt = srr_pkg::ST_POST;
        end
      end
      srr_pkg::ST_POST: begin
        // A reject in this cycle owns the write port; the result follows next cycle
        if (!reject) begin
          statusWe_nxt = 1'b1;
          statusWord_nxt = mkWord(code_r);
          diagCode_nxt = code_r;
          state_nxt = srr_pkg::ST_IDLE;
        end
      end
    endcase
    if (reject) begin
      statusWe_nxt = 1'b1;
      statusWord_nxt = mkWord(srr_pkg::SEC_PORT_BUSY);
      diagCode_nxt = srr_pkg::SEC_PORT_BUSY;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= srr_pkg::ST_IDLE;
      code_r <= srr_pkg::SEC_NONE;
      statusWe_r <= 1'b0;
      statusWord_r <= 16'h0000;
      diagCode_r <= srr_pkg::SEC_NONE;
      xferAbort_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      code_r <= code_nxt;
      statusWe_r <= statusWe_nxt;
      statusWord_r <= statusWord_nxt;
      diagCode_r <= diagCode_nxt;
      xferAbort_r <= xferAbort_nxt;
    end
  end

  assign statusWe = statusWe_r;
  assign statusWord = statusWord_r;
  assign diagCode = diagCode_r;
  assign xferAbort = xferAbort_r;

endmodule // srr_status_reporter

// [srr_status_reporter_asserts.sv]
`timescale 1ns/10ps

module srr_status_reporter_asserts (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Request side
  input wire logic reqStart,
  input wire logic [15:0] reqCmd,
  input wire logic cfgSlave,
  // Results
  input wire logic portBusy,
  input wire logic xferAbort,
  input wire logic statusWe,
  input wire logic [15:0] statusWord,
  input wire logic [7:0] diagCode
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // ****************************************
  // Request decode and result sequences
  // ****************************************
  logic badCmd;
  assign badCmd = (reqCmd < 16'h1771) || (reqCmd > 16'h1773 && reqCmd < 16'h17D5) || (reqCmd > 16'h17E1);

  sequence sqTake;
    reqStart && !portBusy;
  endsequence
  sequence sqBusyReq;
    reqStart && portBusy;
  endsequence
  sequence sqWrite(logic [15:0] w);
    statusWe && statusWord == w;
  endsequence

  a_word_nonzero: assert property (statusWe |-> statusWord != 16'h0000)
    else $error("zero status word written");
  a_ok_low: assert property (statusWe && statusWord[15:8] == 8'h00 |-> statusWord[7:0] == 8'h01)
    else $error("success without low byte one");
  a_fail_low: assert property (statusWe && statusWord[15:8] != 8'h00 |-> statusWord[7:0] > 8'h01)
    else $error("failure low byte not above one");
  a_diag_copy: assert property (statusWe |-> diagCode == statusWord[15:8])
    else $error("diagnostic code differs from status high byte");
  a_busy_reject: assert property (sqBusyReq |=> sqWrite(16'h3002))
    else $error("busy request not rejected");
  a_bad_cmd: assert property (sqTake ##0 badCmd |-> ##[2:3] sqWrite(16'h4102))
    else $error("unknown command not rejected");
  a_query_master: assert property (sqTake ##0 (reqCmd == 16'h1771 && !cfgSlave) |-> ##[2:3] sqWrite(16'h0F02))
    else $error("reply load on non-slave port not rejected");
  a_abort_write: assert property ($rose(xferAbort) |-> ##[1:2] (statusWe && statusWord[7:0] == 8'h02))
    else $error("abort without failure word");
  a_busy_drop: assert property ($fell(portBusy) |-> statusWe)
    else $error("busy dropped without status write");
endmodule // srr_status_reporter_asserts

bind srr_status_reporter srr_status_reporter_asserts u_srr_status_reporter_asserts (.clk(clk), .rst_b(rst_b),
  .reqStart(reqStart), .reqCmd(reqCmd), .cfgSlave(cfgSlave), .portBusy(portBusy), .xferAbort(xferAbort),
  .statusWe(statusWe), .statusWord(statusWord), .diagCode(diagCode));

// [srr_engine_model.sv]
`timescale 1ns/10ps

// Serial engine stand-in: fires a chosen event reps times, one cycle each, two cycles apart
module srr_engine_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Bench commands
  input wire logic go,
  input wire logic [4:0] sel,
  input wire logic [5:0] reps,
  input wire logic ctsHold,
  // Events toward the block
  output logic [14:0] faultCause,
  output logic evtDone,
  output logic blockFail,
  output logic headerFail,
  output logic queryFail,
  output logic enqNoAck,
  output logic enqNak,
  output logic enqNoResp,
  output logic txWait,
  output logic ctsPin
);
  logic [21:0] ev;
  logic [4:0] selR;
  logic [5:0] left;
  logic gap;

  assign {enqNoResp, enqNak, enqNoAck, queryFail, headerFail, blockFail, evtDone, faultCause} = ev;
  // Far side only withholds clear-to-send while asked; it waits to send for as long
  assign txWait = ctsHold;
  assign ctsPin = !ctsHold;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ev <= 22'h000000;
      selR <= 5'h00;
      left <= 6'h00;
      gap <= 1'b0;
    end else begin
      ev <= 22'h000000;
      if (go) begin
        selR <= sel;
        left <= reps;
        gap <= 1'b1;
      end else if (left != 6'h00) begin
        if (gap) begin
          gap <= 1'b0;
        end else begin
          ev <= 22'h000001 << selR;
          left <= left - 6'h01;
          gap <= 1'b1;
        end
      end
    end
  end
endmodule // srr_engine_model

// [srr_status_reporter_test.sv]
`timescale 1ns/10ps

`define CHECK(act, exp) begin samples_checked++; if ((act) !== (exp)) begin failures++; \
  $display("MISMATCH t=%0t act=%h exp=%h", $time, (act), (exp)); end end

module srr_status_reporter_test;
  logic clk, rst_b, reqStart, cfgSlave, go, ctsHold;
  logic [15:0] reqCmd, statusWord, hostStat;
  logic [3:0] cfgRetryLimit;
  logic [5:0] cfgEnqLimit, reps;
  logic [4:0] sel;
  logic [14:0] faultCause;
  logic evtDone, blockFail, headerFail, queryFail, enqNoAck, enqNak, enqNoResp, txWait, ctsPin;
  logic portBusy, xferAbort, statusWe;
  logic [7:0] diagCode;
  logic sawAbort;
  int failures, samples_checked;

  srr_status_reporter #(.CTS_WAIT_CYCLES(8)) u_srr_status_reporter (.clk(clk), .rst_b(rst_b),
    .reqStart(reqStart), .reqCmd(reqCmd), .cfgSlave(cfgSlave), .cfgRetryLimit(cfgRetryLimit),
    .cfgEnqLimit(cfgEnqLimit), .faultCause(faultCause), .evtDone(evtDone), .blockFail(blockFail),
    .headerFail(headerFail), .queryFail(queryFail), .enqNoAck(enqNoAck), .enqNak(enqNak),
    .enqNoResp(enqNoResp), .txWait(txWait), .ctsPin(ctsPin), .portBusy(portBusy), .xferAbort(xferAbort),
    .statusWe(statusWe), .statusWord(statusWord), .diagCode(diagCode));

  srr_engine_model u_srr_engine_model (.clk(clk), .rst_b(rst_b), .go(go), .sel(sel), .reps(reps),
    .ctsHold(ctsHold), .faultCause(faultCause), .evtDone(evtDone), .blockFail(blockFail),
    .headerFail(headerFail), .queryFail(queryFail), .enqNoAck(enqNoAck), .enqNak(enqNak),
    .enqNoResp(enqNoResp), .txWait(txWait), .ctsPin(ctsPin));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Host copy of the status word, as the ladder program would see it
  always @(posedge clk) if (statusWe === 1'b1) hostStat <= statusWord;

  // Sticky record of the abort pulse, cleared by each request issued through start
  always @(posedge clk) if (xferAbort === 1'b1) sawAbort <= 1'b1;

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic final_report();
    $display("Compared %0d values, %0d mismatches", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic tick();
    @(posedge clk);
    #1;
  endtask

  task automatic start(input logic [15:0] cmd);
    hostStat = 16'h0000;
    sawAbort = 1'b0;
    reqCmd = cmd;
    reqStart = 1'b1;
    tick();
    reqStart = 1'b0;
  endtask

  task automatic kick(input logic [4:0] s, input logic [5:0] r);
    sel = s;
    reps = r;
    go = 1'b1;
    tick();
    go = 1'b0;
  endtask

  // Polls the host copy until it turns non-zero, bounded
  task automatic waitStat(input logic [15:0] exp);
    int n;
    n = 0;
    while (hostStat === 16'h0000 && n < 400) begin
      tick();
      n++;
    end
    if (hostStat === 16'h0000) begin
      failures++;
      final_report();
    end
    `CHECK(hostStat, exp)
    `CHECK(diagCode, exp[15:8])
    `CHECK(portBusy, 1'b0)
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_ok();
    `CHECK(statusWord, 16'h0000)
    start(16'h17D5);
    kick(5'h0F, 6'h01);
    waitStat(16'h0001);
    `CHECK(sawAbort, 1'b0)
  endtask

  task automatic t_faults();
    logic [7:0] codes [15] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0A, 8'h0B,
      8'h14, 8'h15, 8'h16, 8'h1D};
    for (int i = 0; i < 15; i++) begin
      start(16'h17E1);
      kick(5'(i), 6'h01);
      waitStat({codes[i], 8'h02});
      `CHECK(sawAbort, 1'b1)
    end
  endtask

  task automatic t_retry();
    for (int j = 0; j < 3; j++) begin
      start(16'h17D5);
      kick(5'(16 + j), 6'h04);
      waitStat({8'h0C + 8'(j), 8'h02});
    end
    start(16'h17D5);
    kick(5'h10, 6'h03);
    repeat (10) tick();
    kick(5'h0F, 6'h01);
    waitStat(16'h0001);
    // One retry allowed: the second header failure must abort
    cfgRetryLimit = 4'h1;
    start(16'h17D5);
    kick(5'h11, 6'h02);
    waitStat(16'h0D02);
    cfgRetryLimit = 4'h0;
  endtask

  task automatic t_enq();
    cfgEnqLimit = 6'h02;
    for (int j = 0; j < 3; j++) begin
      start(16'h17D5);
      kick(5'(19 + j), 6'h02);
      waitStat({8'h17 + 8'(j), 8'h02});
    end
    start(16'h17D5);
    kick(5'h14, 6'h01);
    repeat (6) tick();
    kick(5'h0F, 6'h01);
    waitStat(16'h0001);
    cfgEnqLimit = 6'h00;
    start(16'h17D5);
    kick(5'h13, 6'h20);
    waitStat(16'h1702);
  endtask

  task automatic t_cts();
    ctsHold = 1'b1;
    start(16'h17D5);
    waitStat(16'h1A02);
    `CHECK(sawAbort, 1'b1)
    ctsHold = 1'b0;
  endtask

  task automatic t_cmds();
    logic [15:0] bad [4] = '{16'h1770, 16'h1774, 16'h17D4, 16'h17E2};
    for (int k = 0; k < 4; k++) begin
      start(bad[k]);
      waitStat(16'h4102);
    end
    cfgSlave = 1'b0;
    start(16'h1771);
    waitStat(16'h0F02);
    cfgSlave = 1'b1;
    start(16'h1771);
    waitStat(16'h0001);
  endtask

  task automatic t_busy();
    hostStat = 16'h0000;
    reqCmd = 16'h17D5;
    reqStart = 1'b1;
    tick();
    tick();
    reqStart = 1'b0;
    `CHECK(statusWe, 1'b1)
    `CHECK(statusWord, 16'h3002)
    `CHECK(portBusy, 1'b1)
    `CHECK(diagCode, 8'h30)
    // The reject word reaches the host copy on the next edge; clear it after that
    kick(5'h0F, 6'h01);
    hostStat = 16'h0000;
    waitStat(16'h0001);
  endtask

  initial begin
    rst_b = 1'b0;
    reqStart = 1'b0;
    reqCmd = 16'h0000;
    cfgSlave = 1'b0;
    cfgRetryLimit = 4'h0;
    cfgEnqLimit = 6'h00;
    go = 1'b0;
    sel = 5'h00;
    reps = 6'h00;
    ctsHold = 1'b0;
    hostStat = 16'h0000;
    failures = 0;
    samples_checked = 0;
    repeat (8) @(posedge clk);
    #1;
    rst_b = 1'b1;
    t_ok();
    t_faults();
    t_retry();
    t_enq();
    t_cts();
    t_cmds();
    t_busy();
    final_report();
  end
endmodule // srr_status_reporter_test
